// ===== core/flash_ctl_pkg.sv
package flash_ctl_pkg;

   localparam int unsigned SYS_CLK_MHZ       = 40;
   localparam int unsigned ADDR_W            = 18;

   // timing, figures in microseconds
   localparam int unsigned ERASE_TIMEOUT_US  = 96;
   localparam int unsigned PROT_FLAG_US      = 100;
   localparam int unsigned RESET_ENTRY_US    = 2;
   localparam int unsigned SUSPEND_MAX_US    = 15;
   localparam int unsigned PROG_US           = 16;
   localparam int unsigned PROG_CYC          = PROG_US * SYS_CLK_MHZ;
   localparam int unsigned ERASE_TIMEOUT_CYC = ERASE_TIMEOUT_US * SYS_CLK_MHZ;
   localparam int unsigned PROT_FLAG_CYC     = PROT_FLAG_US * SYS_CLK_MHZ;
   localparam int unsigned RESET_ENTRY_CYC   = RESET_ENTRY_US * SYS_CLK_MHZ;
   localparam int unsigned SUSPEND_CYC       = SUSPEND_MAX_US * SYS_CLK_MHZ;
   localparam int unsigned TMR_W             = 13;

   // command interface addresses and codes (low byte)
   localparam logic [15:0] UNLOCK_ADDR1      = 16'h1554;
   localparam logic [15:0] UNLOCK_ADDR2      = 16'h2AA8;
   localparam logic [7:0]  CODE_UNLOCK1      = 8'hA8;
   localparam logic [7:0]  CODE_UNLOCK2      = 8'h54;
   localparam logic [7:0]  CODE_READ_RESET   = 8'hF0;
   localparam logic [7:0]  CODE_PROGRAM      = 8'hA0;
   localparam logic [7:0]  CODE_ERASE_SETUP  = 8'h80;
   localparam logic [7:0]  CODE_BLOCK_ERASE  = 8'h30;
   localparam logic [7:0]  CODE_CHIP_ERASE   = 8'h10;
   localparam logic [7:0]  CODE_SUSPEND      = 8'hB0;
   localparam logic [7:0]  CODE_RESUME       = 8'h30;
   localparam logic [7:0]  CODE_SET_PROTECT  = 8'hC0;
   localparam logic [7:0]  CODE_READ_PROTECT = 8'h90;

   // status word field positions, block count and protection reset value
   localparam int unsigned DATA_POLL_POS     = 7;
   localparam int unsigned TOGGLE1_POS       = 6;
   localparam int unsigned ERROR_POS         = 5;
   localparam int unsigned TIMEOUT_POS       = 3;
   localparam int unsigned TOGGLE2_POS       = 2;
   localparam int unsigned NUM_BLOCKS        = 7;
   localparam logic [15:0] PROT_RESET        = 16'hFFFF;

   typedef enum logic [10:0] {
      ST_READ     = 11'h001,
      ST_UNLK1    = 11'h002,
      ST_UNLK2    = 11'h004,
      ST_PROG_WAIT= 11'h008,
      ST_ERS_U0   = 11'h010,
      ST_ERS_U1   = 11'h020,
      ST_ERS_U2   = 11'h040,
      ST_ERS_TMO  = 11'h080,
      ST_BUSY     = 11'h100,
      ST_SUSPEND  = 11'h200,
      ST_PROT_WAIT= 11'h400
   } seq_state_t;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [15:0]       wdata;
   } cpu_req_t;

   typedef struct packed {
      logic        start;
      logic        is_erase;
      logic        is_prot;
      logic [ADDR_W-1:0] addr;
      logic [15:0] data;
      logic [NUM_BLOCKS-1:0] blocks;
   } op_cmd_t;

   function automatic logic [2:0] block_of(input logic [ADDR_W-1:0] a);
      if (a[17:16] == 2'd0)
         return (a[15:14] == 2'd0) ? 3'd0 : (a[15:13] == 3'd2) ? 3'd1 :
                (a[15:13] == 3'd3) ? 3'd2 : 3'd3;
      else if (a[17:16] == 2'd1)
         return 3'd3;
      else
         return 3'(a[17:16]) + 3'd2;
   endfunction

endpackage

// ===== core/flash_array.sv
`timescale 1ns/100ps
`default_nettype none
// behavioural flash array, 32-bit aligned reads, 16-bit word programs
module flash_array (
   input  wire logic                              sys_clk,
   input  wire logic                              reset,
   input  wire logic                              ce,
   input  wire logic [flash_ctl_pkg::ADDR_W-1:0]  rd_addr,
   output logic      [31:0]                       rd_data,
   input  wire logic                              prog_en,
   input  wire logic [flash_ctl_pkg::ADDR_W-1:0]  prog_addr,
   input  wire logic [15:0]                       prog_data,
   input  wire logic                              erase_en,
   input  wire logic [flash_ctl_pkg::NUM_BLOCKS-1:0] erase_blocks,
   output logic                                   prog_fail
);
   import flash_ctl_pkg::*;

   // small model store; segment taken from the top address bits
   logic [15:0]  mem [0:255];
   logic [255:0] erased_ff;
   logic [7:0]   widx;
   logic [7:0]   ridx;

   // the store has no reset; a blank flag per word stands in for erased cells
   function automatic logic [15:0] word_of(input logic blank, input logic [15:0] w);
      return blank ? 16'hFFFF : w;
   endfunction

   assign widx      = {prog_addr[17:16], prog_addr[6:1]};
   assign ridx      = {rd_addr[17:16], rd_addr[6:2], 1'b0}; // RULE4 RULE5
   // read is combinational so the controller registers it on the read edge
   assign rd_data   = {word_of(erased_ff[ridx + 8'd1], mem[ridx + 8'd1]),
                       word_of(erased_ff[ridx], mem[ridx])};
   assign prog_fail = |(prog_data & ~word_of(erased_ff[widx], mem[widx])); // RULE18

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset)
         erased_ff <= '1;
      else if (ce) begin
         if (prog_en)
            erased_ff[widx] <= 1'b0;
         if (erase_en) begin
            for (int i = 0; i < 256; i++)
               if (erase_blocks[block_of({i[7:6], 10'h000, i[5:0]})])
                  erased_ff[i] <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ce && prog_en)
         mem[widx] <= word_of(erased_ff[widx], mem[widx]) & prog_data;
   end
endmodule
`default_nettype wire

// ===== core/op_timer.sv
`timescale 1ns/100ps
`default_nettype none
module op_timer (
   input  wire logic                      sys_clk,
   input  wire logic                      reset,
   input  wire logic                      ce,
   input  wire logic                      load,
   input  wire logic [flash_ctl_pkg::TMR_W-1:0] count,
   output logic                           done
);
   import flash_ctl_pkg::*;

   logic [TMR_W-1:0] cnt_ff;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         // leaves reset already timing the read-mode entry delay
         cnt_ff <= TMR_W'(RESET_ENTRY_CYC);
         done   <= 1'b0;
      end else if (ce) begin
         done <= (cnt_ff == TMR_W'(1)) && !load;
         if (load)
            cnt_ff <= count;
         else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - TMR_W'(1);
      end
   end
endmodule
`default_nettype wire

// ===== core/flash_mode_ctl.sv
// Summary of operation
// RULE1: enter read mode after reset command, op completion, and shortly after cpu reset
// RULE2: bad address, data or order in a sequence returns to read mode
// RULE3: stay in read mode until the launching final write is decoded
// RULE4: reads return an aligned 32-bit double word, a1 and a0 ignored
// RULE5: top address bits pick the 64k byte segment
// RULE6: write address plus current state selects the sequence step
// RULE7: controller starts exactly at the last sequence write
// RULE8: ready/busy high while busy, low when idle or suspended
// RULE9: ready/busy feeds a pollable node; busy-to-ready raises an event
// RULE10: reads during operation return status bits 7,6,5,3,2, rest zero
// RULE11: host reads status at programmed word or inside erased block
// RULE12: program: polling bit is inverse of data bit 7, then true bit 7
// RULE13: erase: polling bit reads 0, then 1 when done
// RULE14: erase of only protected blocks: polling 0 for about 100 us
// RULE15: suspend drives polling bit 0 to 1; suspended programs behave normally
// RULE16: first toggle inverts each status read; after done last bit or 1
// RULE17: first toggle reads 1 on suspended block, toggles on suspend/resume
// RULE18: error bit set on failed program or erase, or 0-to-1 program
// RULE19: read/reset clears error; success gives 0 then last bit or 1
// RULE20: timeout bit clears on erase confirm, returns to 1 after 96 us
// RULE21: second toggle inverts on erase reads and suspended block accesses
// RULE22: suspended program reads 1 at its address; error erase toggles faulty block
// RULE23: unlock pair is a8 at 1554h then 54 at 2aa8h
// RULE24: f0 write is read/reset; host waits 10 us after one during an op
// RULE25: b0 write suspends erase, no unlock, effective within 15 us
// RULE26: protection bits default 1 and can only be programmed to 0
// RULE27: protection register read by its command, written only by set protection
// RULE28: idle in read mode, reads return array data
`timescale 1ns/100ps
`default_nettype none
module flash_mode_ctl (
   input  wire logic                  sys_clk,
   input  wire logic                  reset,
   input  wire logic                  ce,
   input  wire flash_ctl_pkg::cpu_req_t req,
   output logic [31:0]                rd_data,
   output logic                       ready_busy,
   output logic                       ready_event,
   output logic [15:0]                ext_periph2_int_control
);
   import flash_ctl_pkg::*;

   typedef struct packed {
      seq_state_t            st;
      logic [2:0]            phase;     // which command path after unlock
      logic                  toggle1;
      logic                  toggle2;
      logic                  error;
      logic                  timeout_bit;
      logic                  done_erase;
      logic                  prot_flag;
      logic                  sus_prog;
      logic                  status_rd;
      logic                  prot_rd;
      logic                  boot_wait;
      logic                  busy_q;
      logic [ADDR_W-1:0]     op_addr;
      logic [15:0]           op_data;
      logic [NUM_BLOCKS-1:0] blocks;
      logic [NUM_BLOCKS-1:0] sus_blocks;
      logic [15:0]           prot;
      logic [31:0]           rd_data;
      logic                  ready_busy;
      logic                  ready_event;
   } ctl_state_t;

   ctl_state_t s_ff, nxt_s;

   logic               tmr_load, tmr_done, arr_prog, arr_erase, prog_fail;
   logic [TMR_W-1:0]   tmr_count;
   logic [31:0]        arr_data;
   logic [15:0]        status;

   op_timer u_timer (
      .sys_clk (sys_clk),
      .reset   (reset),
      .ce      (ce),
      .load    (tmr_load),
      .count   (tmr_count),
      .done    (tmr_done)
   );

   flash_array u_array (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .ce           (ce),
      .rd_addr      (req.addr),
      .rd_data      (arr_data),
      .prog_en      (arr_prog),
      .prog_addr    (req.addr),
      .prog_data    (req.wdata),
      .erase_en     (arr_erase),
      .erase_blocks (s_ff.blocks),
      .prog_fail    (prog_fail)
   );

   function automatic logic is_unlock1(input cpu_req_t r);
      return r.addr[15:0] == UNLOCK_ADDR1 && r.wdata[7:0] == CODE_UNLOCK1;
   endfunction

   function automatic logic is_unlock2(input cpu_req_t r);
      return r.addr[15:0] == UNLOCK_ADDR2 && r.wdata[7:0] == CODE_UNLOCK2;
   endfunction

   assign ext_periph2_int_control = {15'h0000, s_ff.ready_busy};   // RULE9

   always_comb begin
      logic [2:0] blk;
      logic       in_op;
      logic       sus_hit;
      blk       = block_of(req.addr);
      nxt_s     = s_ff;
      tmr_load  = 1'b0;
      tmr_count = '0;
      arr_prog  = 1'b0;
      arr_erase = 1'b0;
      in_op     = (s_ff.st == ST_BUSY) || (s_ff.st == ST_ERS_TMO) || s_ff.prot_flag;
      sus_hit   = (s_ff.st == ST_SUSPEND) && s_ff.sus_blocks[blk];
      nxt_s.ready_event = 1'b0;

      // status word, reserved bits zero
      status = 16'h0000;                                            // RULE10
      if (s_ff.phase == 3'd1 || s_ff.sus_prog)
         status[DATA_POLL_POS] = in_op ? ~s_ff.op_data[7] : s_ff.op_data[7]; // RULE12 RULE15
      else
         status[DATA_POLL_POS] = !in_op || sus_hit;                 // RULE13 RULE14 RULE15
      status[TOGGLE1_POS] = sus_hit ? 1'b1 : s_ff.toggle1;          // RULE16 RULE17
      status[ERROR_POS]   = s_ff.error;                             // RULE18 RULE19
      status[TIMEOUT_POS] = s_ff.timeout_bit;                       // RULE20
      status[TOGGLE2_POS] = (s_ff.sus_prog && req.addr == s_ff.op_addr) ? 1'b1
                            : s_ff.toggle2;                         // RULE22

      if (req.rd) begin
         if (s_ff.prot_rd)
            nxt_s.rd_data = {16'h0000, s_ff.prot};                  // RULE27
         else if (in_op || sus_hit || (s_ff.error && s_ff.blocks[blk])) begin
            nxt_s.rd_data = {status, status};                       // RULE10 RULE11
            nxt_s.toggle1 = ~s_ff.toggle1;                          // RULE16
            if (s_ff.st == ST_BUSY && s_ff.phase != 3'd1 || sus_hit || s_ff.error)
               nxt_s.toggle2 = ~s_ff.toggle2;                       // RULE21 RULE22
         end else
            nxt_s.rd_data = arr_data;                               // RULE4 RULE5 RULE28
      end

      // a cpu write sequence; address plus state pick the step
      if (req.wr) begin                                             // RULE6
         if (req.wdata[7:0] == CODE_READ_RESET && s_ff.st != ST_PROG_WAIT) begin
            nxt_s.st       = ST_READ;                                // RULE1 RULE24
            nxt_s.error    = 1'b0;                                   // RULE19
            nxt_s.prot_rd  = 1'b0;
            nxt_s.sus_prog = 1'b0;
            nxt_s.phase    = 3'd0;
            nxt_s.timeout_bit = 1'b1;
         end else begin
            unique case (s_ff.st)
               ST_READ:   nxt_s.st = is_unlock1(req) ? ST_UNLK1 : ST_READ;  // RULE23
               ST_UNLK1:  nxt_s.st = is_unlock2(req) ? ST_UNLK2 : ST_READ;  // RULE2 RULE23
               ST_UNLK2: begin
                  nxt_s.st = ST_READ;                                // RULE2
                  if (req.addr[15:0] == UNLOCK_ADDR1) begin
                     unique case (req.wdata[7:0])
                        CODE_PROGRAM:      nxt_s.st = ST_PROG_WAIT;
                        CODE_ERASE_SETUP:  nxt_s.st = ST_ERS_U0;
                        CODE_SET_PROTECT:  nxt_s.st = ST_PROT_WAIT;
                        CODE_READ_PROTECT: nxt_s.prot_rd = 1'b1;     // RULE27
                        default:           nxt_s.st = ST_READ;
                     endcase
                  end
               end
               ST_PROG_WAIT: begin
                  // final write launches programming, suspended or not
                  nxt_s.op_addr  = req.addr;                         // RULE3 RULE7
                  nxt_s.op_data  = req.wdata;
                  nxt_s.phase    = 3'd1;
                  nxt_s.error    = 1'b0;
                  nxt_s.sus_prog = (s_ff.sus_blocks != '0);
                  nxt_s.st       = ST_BUSY;
                  if (!s_ff.prot[block_of(req.addr)] || prog_fail) begin
                     nxt_s.error = 1'b1;                             // RULE18
                  end
                  arr_prog  = s_ff.prot[block_of(req.addr)];
                  tmr_load  = 1'b1;
                  tmr_count = TMR_W'(PROG_CYC);
               end
               ST_ERS_U0: nxt_s.st = is_unlock1(req) ? ST_ERS_U1 : ST_READ; // RULE2
               ST_ERS_U1: nxt_s.st = is_unlock2(req) ? ST_ERS_U2 : ST_READ;
               ST_ERS_U2: begin
                  nxt_s.st = ST_READ;                                // RULE2
                  nxt_s.op_data = 16'hFFFF;
                  nxt_s.phase = 3'd2;
                  if (req.wdata[7:0] == CODE_CHIP_ERASE && req.addr[15:0] == UNLOCK_ADDR1) begin
                     nxt_s.blocks = '1;                              // RULE7
                     nxt_s.st     = ST_BUSY;
                     tmr_load     = 1'b1;
                     tmr_count    = TMR_W'(ERASE_TIMEOUT_CYC);
                  end else if (req.wdata[7:0] == CODE_BLOCK_ERASE) begin
                     nxt_s.blocks      = '0;
                     nxt_s.blocks[blk] = 1'b1;
                     nxt_s.st          = ST_ERS_TMO;
                     nxt_s.timeout_bit = 1'b0;                       // RULE20
                     tmr_load          = 1'b1;
                     tmr_count         = TMR_W'(ERASE_TIMEOUT_CYC);
                  end
               end
               ST_ERS_TMO: begin
                  if (req.wdata[7:0] == CODE_BLOCK_ERASE) begin
                     nxt_s.blocks[blk] = 1'b1;                       // timeout restarts
                     tmr_load          = 1'b1;
                     tmr_count         = TMR_W'(ERASE_TIMEOUT_CYC);
                  end else if (req.wdata[7:0] == CODE_SUSPEND) begin
                     nxt_s.st          = ST_SUSPEND;
                     nxt_s.sus_blocks  = s_ff.blocks;
                     nxt_s.timeout_bit = 1'b1;
                     nxt_s.toggle1     = ~s_ff.toggle1;              // RULE17
                  end else
                     nxt_s.st = ST_READ;                             // RULE2
               end
               ST_BUSY: begin
                  // only suspend of a running erase, or the read/reset taken above, is accepted while busy; new program or erase refused
                  if (req.wdata[7:0] == CODE_SUSPEND && s_ff.phase == 3'd2 && !s_ff.sus_prog) begin
                     nxt_s.st         = ST_SUSPEND;                  // RULE25
                     nxt_s.sus_blocks = s_ff.blocks;
                     nxt_s.toggle1    = ~s_ff.toggle1;               // RULE17
                  end
               end
               ST_SUSPEND: begin
                  if (req.wdata[7:0] == CODE_RESUME) begin
                     nxt_s.st         = ST_BUSY;
                     nxt_s.sus_blocks = '0;
                     nxt_s.toggle1    = ~s_ff.toggle1;               // RULE17
                     tmr_load         = 1'b1;
                     tmr_count        = TMR_W'(ERASE_TIMEOUT_CYC);
                  end else if (is_unlock1(req))
                     nxt_s.st = ST_UNLK1;
               end
               ST_PROT_WAIT: begin
                  // bits only go from 1 to 0
                  nxt_s.prot  = s_ff.prot & req.wdata;               // RULE26 RULE27
                  nxt_s.st    = ST_BUSY;                             // RULE7
                  nxt_s.phase = 3'd3;
                  tmr_load    = 1'b1;
                  tmr_count   = TMR_W'(PROG_CYC);
               end
               default: nxt_s.st = ST_READ;
            endcase
         end
      end

      // timer expiry
      if (tmr_done) begin
         if (s_ff.boot_wait)
            nxt_s.boot_wait = 1'b0;                                  // RULE1
         else if (s_ff.prot_flag)
            nxt_s.prot_flag = 1'b0;                                  // RULE14
         else if (s_ff.st == ST_ERS_TMO) begin
            nxt_s.timeout_bit = 1'b1;                                // RULE20
            if ((s_ff.blocks & s_ff.prot[NUM_BLOCKS-1:0]) == '0) begin
               nxt_s.st        = ST_READ;                            // RULE14
               nxt_s.prot_flag = 1'b1;
               tmr_load        = 1'b1;
               tmr_count       = TMR_W'(PROT_FLAG_CYC);
            end else begin
               nxt_s.blocks = s_ff.blocks & s_ff.prot[NUM_BLOCKS-1:0];
               nxt_s.st     = ST_BUSY;                               // RULE7
               tmr_load     = 1'b1;
               tmr_count    = TMR_W'(ERASE_TIMEOUT_CYC);
            end
         end else if (s_ff.st == ST_BUSY) begin
            arr_erase      = (s_ff.phase == 3'd2);
            nxt_s.st       = s_ff.sus_prog ? ST_SUSPEND : ST_READ;   // RULE1
            nxt_s.sus_prog = 1'b0;
            nxt_s.phase    = 3'd0;
         end
      end

      nxt_s.busy_q      = (nxt_s.st == ST_BUSY) || (nxt_s.st == ST_ERS_TMO);
      nxt_s.ready_busy  = nxt_s.busy_q || s_ff.boot_wait;            // RULE8
      nxt_s.ready_event = s_ff.busy_q && !nxt_s.busy_q;              // RULE9
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         s_ff             <= '0;
         s_ff.st          <= ST_READ;
         s_ff.timeout_bit <= 1'b1;
         s_ff.prot        <= PROT_RESET;
         s_ff.boot_wait   <= 1'b1;                                   // RULE1
      end else if (ce)
         s_ff <= nxt_s;
   end

   assign rd_data     = s_ff.rd_data;
   assign ready_busy  = s_ff.ready_busy;
   assign ready_event = s_ff.ready_event;

   a_prot_only_down: assert property (@(posedge sys_clk) disable iff (reset)
      ce |=> ((s_ff.prot & ~$past(s_ff.prot)) == '0))           // RULE26
      else $error("protection bit returned to one");
   a_busy_line: assert property (@(posedge sys_clk) disable iff (reset)
      (s_ff.st == ST_SUSPEND) |-> !s_ff.ready_busy)             // RULE8
      else $error("busy during suspend");
   a_reserved_zero: assert property (@(posedge sys_clk) disable iff (reset)
      (status[15:8] == 8'h00) && !status[4] && (status[1:0] == 2'b00)) // RULE10
      else $error("reserved status bits driven");
   a_reset_clears: assert property (@(posedge sys_clk) disable iff (reset)
      (ce && req.wr && req.wdata[7:0] == CODE_READ_RESET && s_ff.st != ST_PROG_WAIT)
      |=> !s_ff.error && s_ff.st == ST_READ)                     // RULE19
      else $error("read reset did not clear");
   a_timeout_low: assert property (@(posedge sys_clk) disable iff (reset)
      (s_ff.st == ST_ERS_TMO) |-> !s_ff.timeout_bit)             // RULE20
      else $error("timeout bit high while waiting");
   a_unlock_bad: assert property (@(posedge sys_clk) disable iff (reset)
      (ce && s_ff.st == ST_UNLK1 && req.wr && !is_unlock2(req)) |=> s_ff.st == ST_READ) // RULE2
      else $error("bad unlock not rejected");
   a_launch_prog: assert property (@(posedge sys_clk) disable iff (reset)
      (ce && s_ff.st == ST_PROG_WAIT && req.wr && req.wdata[7:0] != CODE_READ_RESET)
      |=> s_ff.st == ST_BUSY ##1 s_ff.ready_busy)                // RULE7
      else $error("program not launched");
   a_ready_event: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(s_ff.ready_event) |-> $past(s_ff.busy_q))            // RULE9
      else $error("ready event without busy");
   c_program: cover property (@(posedge sys_clk) s_ff.st == ST_BUSY && s_ff.phase == 3'd1);
   c_suspend: cover property (@(posedge sys_clk) s_ff.st == ST_SUSPEND);
   c_prot_flag: cover property (@(posedge sys_clk) s_ff.prot_flag);
endmodule
`default_nettype wire

// ===== testbench/cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
   input  wire logic                     sys_clk,
   output var  flash_ctl_pkg::cpu_req_t  req,
   input  wire logic [31:0]              rd_data
);
   import flash_ctl_pkg::*;
   initial req = '0;
   // idle address and data show the inverse, never the last value
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      req <= '{wr:1'b1, rd:1'b0, addr:a, wdata:d};
      @(negedge sys_clk);
      req <= '{wr:1'b0, rd:1'b0, addr:~a, wdata:~d};
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
      @(negedge sys_clk);
      req <= '{wr:1'b0, rd:1'b1, addr:a, wdata:16'h0000};
      @(negedge sys_clk);
      req <= '{wr:1'b0, rd:1'b0, addr:~a, wdata:16'hFFFF};
      @(negedge sys_clk);
      q = rd_data;
   endtask
   task automatic cmd(input logic [7:0] c);
      wr(18'(UNLOCK_ADDR1), {8'h00, CODE_UNLOCK1});
      wr(18'(UNLOCK_ADDR2), {8'h00, CODE_UNLOCK2});
      wr(18'(UNLOCK_ADDR1), {8'h00, c});
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
   import flash_ctl_pkg::*;
   logic             sys_clk = 1'b0;
   logic             reset = 1'b1;
   logic             ce = 1'b1;
   cpu_req_t         req;
   logic [31:0]      rd_data, q, q2;
   logic             ready_busy, ready_event;
   logic [15:0]      ext_periph2_int_control, d;
   logic [ADDR_W-1:0] a;
   int               mismatches = 0, tests_run = 0, cyc = 0, seed, n;
   always #12.5 sys_clk = ~sys_clk;
   flash_mode_ctl i_flash_mode_ctl (.sys_clk(sys_clk), .reset(reset), .ce(ce), .req(req),
      .rd_data(rd_data), .ready_busy(ready_busy), .ready_event(ready_event),
      .ext_periph2_int_control(ext_periph2_int_control));
   cpu_model u_cpu (.sys_clk(sys_clk), .req(req), .rd_data(rd_data));
   function automatic logic [31:0] exp_prog(input logic [15:0] w);
      return {2{8'h00, ~w[7], 7'h00}};
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_rb(input logic lvl, input int lim);
      n = 0;
      while (ready_busy !== lvl && n < lim) begin
         @(negedge sys_clk);
         n++;
      end
      check(32'(ready_busy), 32'(lvl));
   endtask
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ceiling well above the programs, the failure and the resumed 96 us erase
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   initial begin
      seed = $urandom(32'h4C30);
      #50 reset = 1'b0;
      repeat (2) @(negedge sys_clk);
      check(32'(ready_busy), 1);
      wait_rb(1'b0, 400);
      u_cpu.rd(18'h000F0, q);
      u_cpu.rd(18'h000F3, q2);
      check(q2, q);
      u_cpu.cmd(8'h77);
      u_cpu.wr(18'h000F0, 16'h0000);
      check(32'(ready_busy), 0);
      u_cpu.rd(18'h000F0, q2);
      check(q2, q);
      for (int i = 0; i < 3; i++) begin
         a = 18'(i * 16 + 4 * $urandom_range(3));
         d = 16'($urandom);
         u_cpu.cmd(CODE_PROGRAM);
         u_cpu.wr(a, d);
         u_cpu.rd(a, q);
         u_cpu.rd(a, q2);
         check(q & 32'h00A000A0, exp_prog(d));
         check(q & 32'hFF13FF13, 0);
         check(32'(q[6] ^ q2[6]), 1);
         check(32'(ready_busy), 1);
         n = 0;
         while (ready_event !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
         end
         check(32'(ready_event), 1);
         @(negedge sys_clk);
         check(32'(ext_periph2_int_control), 0);
         u_cpu.rd(a, q);
         check(32'(q[15:0]), 32'(d));
      end
      u_cpu.cmd(CODE_PROGRAM);
      u_cpu.wr(a, ~d);
      u_cpu.rd(a, q);
      check(32'(q[ERROR_POS]), 1);
      u_cpu.wr(a, {8'h00, CODE_READ_RESET});
      repeat (400) @(negedge sys_clk);
      wait_rb(1'b0, 1000);
      u_cpu.rd(a, q);
      // the refused word still pulls down the bits it could
      check(32'(q[15:0]), 32'(d & ~d));
      u_cpu.cmd(CODE_ERASE_SETUP);
      u_cpu.cmd(CODE_BLOCK_ERASE);
      u_cpu.wr(18'h00000, {8'h00, CODE_BLOCK_ERASE});
      u_cpu.rd(18'h00000, q);
      check(q & 32'h00880088, 0);
      u_cpu.wr(18'h00000, {8'h00, CODE_SUSPEND});
      repeat (SUSPEND_CYC) @(negedge sys_clk);
      u_cpu.rd(18'h00000, q);
      check(q & 32'h00C800C8, 32'h00C800C8);
      check(32'(ready_busy), 0);
      u_cpu.wr(18'h00000, {8'h00, CODE_RESUME});
      u_cpu.rd(18'h00000, q);
      check(q & 32'h00800080, 0);
      wait_rb(1'b0, 4000);
      u_cpu.rd(a, q);
      check(q, 32'hFFFFFFFF);
      finish_test();
   end
endmodule
`default_nettype wire
